// ===== core/eirq_edge.sv
// Falling edge detector for the active-low request pin.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/100ps
module eirq_edge (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin_n,
    output logic      pin_q,
    output logic      fall
);
    logic prev_reg;

    // Reset as low so a pin held low through reset gives no false edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= pin_n;
        end
    end

    assign pin_q = prev_reg;
    assign fall  = prev_reg & ~pin_n;
endmodule : eirq_edge

// ===== core/eirq_latch.sv
// External interrupt request latch with AHB-Lite register access.
// Assumes irq_pin_n synchronous to hclk; vec_fetch is a one-cycle core pulse.
`timescale 1ns/100ps
module eirq_latch
    import eirq_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        irq_pin_n,
    input  wire logic        vec_fetch,
    input  wire logic        interrupt_mask_flag,
    output logic             vec_req,
    output logic             pin_level,
    output logic             irq
);
    logic              latch_reg;
    logic              mode_reg;
    logic              mask_reg;
    logic [EV_W-1:0]   stat_reg;
    logic [EV_W-1:0]   evmask_reg;
    logic              wr_pend_reg;
    logic [7:0]        wr_addr_reg;
    logic [31:0]       hrdata_reg;
    logic              vec_req_reg;
    logic              pin_level_reg;
    logic              irq_reg;
    logic              latch_next;
    logic [EV_W-1:0]   stat_next;
    logic              pin_q;
    logic              fall;
    logic              addr_ok;
    logic              rd_go;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_mask;
    logic              sw_ack;
    logic              ack;
    logic              level_hold;
    logic [31:0]       rd_mux;
    logic [EV_W-1:0]   ev_now;
    logic              acked_reg;
    logic              acked_next;
    logic              clr_ok;
    logic              rd_ctrl;

    eirq_edge u_edge (
        .clk   (hclk),
        .rst_n (hresetn),
        .pin_n (irq_pin_n),
        .pin_q (pin_q),
        .fall  (fall)
    );

    function automatic logic is_off(input logic [7:0] a, input logic [7:0] ofs);
        is_off = (a == ofs);
    endfunction : is_off

    // Address phase decode; writes land in the following data phase
    assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
    assign rd_go   = addr_ok & ~hwrite;
    assign wr_ctrl = wr_pend_reg & is_off(wr_addr_reg, EIRQ_CTRL_OFS);
    assign wr_stat = wr_pend_reg & is_off(wr_addr_reg, EIRQ_STAT_OFS);
    assign wr_mask = wr_pend_reg & is_off(wr_addr_reg, EIRQ_MASK_OFS);

    assign sw_ack = wr_ctrl & hwdata[CTRL_ACK_POS];
    assign ack    = sw_ack | vec_fetch;

    // Level mode holds the request while the pin is low
    assign level_hold = mode_reg & ~irq_pin_n;
    // Edge wins over a same-cycle acknowledge so no edge is lost
    assign clr_ok     = mode_reg ? ((ack | acked_reg) & irq_pin_n) : ack;
    assign latch_next = fall | level_hold | (latch_reg & ~clr_ok);
    // Remembers an ack taken while the pin was still low
    assign acked_next = mode_reg & latch_next & ~fall & (ack | acked_reg);
    assign rd_ctrl    = rd_go & is_off(haddr[7:0], EIRQ_CTRL_OFS);

    assign ev_now    = {ack, fall};
    assign stat_next = (stat_reg & ~(wr_stat ? hwdata[EV_W-1:0] : EV_RESET)) | ev_now;

    // Ack bit is not stored, so it reads as zero
    assign rd_mux = is_off(haddr[7:0], EIRQ_CTRL_OFS) ?
                        {27'h0000000, irq_pin_n, latch_reg, 1'b0, mask_reg, mode_reg} :
                    is_off(haddr[7:0], EIRQ_STAT_OFS) ? {30'h00000000, stat_reg} :
                    is_off(haddr[7:0], EIRQ_MASK_OFS) ? {30'h00000000, evmask_reg} :
                    RDATA_RESET;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            latch_reg <= 1'b0;
            mode_reg  <= MODE_RESET;
            acked_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            acked_reg <= acked_next;
            if (wr_ctrl) begin
                mode_reg <= hwdata[CTRL_MODE_POS];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_reg   <= MASK_RESET;
            stat_reg   <= EV_RESET;
            evmask_reg <= EV_RESET;
        end else begin
            stat_reg <= stat_next;
            if (wr_ctrl) begin
                mask_reg <= hwdata[CTRL_MASK_POS];
            end
            if (wr_mask) begin
                evmask_reg <= hwdata[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg  <= RDATA_RESET;
        end else begin
            wr_pend_reg <= addr_ok & hwrite;
            if (addr_ok) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (rd_go) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // Outputs registered: one cycle of latency traded for clean timing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vec_req_reg   <= 1'b0;
            pin_level_reg <= 1'b1;
            irq_reg       <= 1'b0;
        end else begin
            vec_req_reg   <= latch_next & ~mask_reg & ~interrupt_mask_flag;
            pin_level_reg <= irq_pin_n;
            irq_reg       <= |(stat_next & evmask_reg);
        end
    end

    assign hrdata    = hrdata_reg;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign vec_req   = vec_req_reg;
    assign pin_level = pin_level_reg;
    assign irq       = irq_reg;

    property p_fall_sets;
        @(posedge hclk) disable iff (!hresetn)
        fall |=> latch_reg;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("edge did not set latch");

    property p_ack_clears;
        @(posedge hclk) disable iff (!hresetn)
        (ack && !fall && !level_hold) |=> !latch_reg;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear latch");

    property p_level_holds;
        @(posedge hclk) disable iff (!hresetn)
        (mode_reg && !irq_pin_n && !wr_ctrl) |=> latch_reg;
    endproperty
    a_level_holds: assert property (p_level_holds) else $error("level mode dropped");

    property p_edge_mode;
        @(posedge hclk) disable iff (!hresetn)
        (!mode_reg && !fall && !ack) |=> (latch_reg == $past(latch_reg));
    endproperty
    a_edge_mode: assert property (p_edge_mode) else $error("edge mode latch moved");

    property p_mask_blocks;
        @(posedge hclk) disable iff (!hresetn)
        (mask_reg || interrupt_mask_flag) |=> !vec_req;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked request seen");

    property p_present;
        @(posedge hclk) disable iff (!hresetn)
        (latch_next && !mask_reg && !interrupt_mask_flag) |=> vec_req;
    endproperty
    a_present: assert property (p_present) else $error("request not presented");

    property p_pin_level;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (pin_level == $past(irq_pin_n));
    endproperty
    a_pin_level: assert property (p_pin_level) else $error("pin level stale");

    property p_ack_reads_zero;
        @(posedge hclk) disable iff (!hresetn)
        (rd_go && is_off(haddr[7:0], EIRQ_CTRL_OFS)) |=> !hrdata[CTRL_ACK_POS];
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack bit read one");

    property p_sw_ack;
        @(posedge hclk) disable iff (!hresetn)
        (sw_ack && !fall && !level_hold) ##1 (!fall && !level_hold) [*2] |-> !latch_reg;
    endproperty
    a_sw_ack: assert property (p_sw_ack) else $error("software ack failed");

    property p_prev_tracks;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (pin_q == $past(irq_pin_n));
    endproperty
    a_prev_tracks: assert property (p_prev_tracks) else $error("edge history stale");

    property p_fall_shape;
        @(posedge hclk) disable iff (!hresetn)
        fall |-> ($past(irq_pin_n) && !irq_pin_n);
    endproperty
    a_fall_shape: assert property (p_fall_shape) else $error("edge without fall");

    property p_set_cause;
        @(posedge hclk) disable iff (!hresetn)
        $rose(latch_reg) |-> $past(fall || level_hold);
    endproperty
    a_set_cause: assert property (p_set_cause) else $error("latch set unprompted");

    property p_clear_cause;
        @(posedge hclk) disable iff (!hresetn)
        $fell(latch_reg) |-> $past(clr_ok);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("latch cleared early");

    property p_mask_keeps;
        @(posedge hclk) disable iff (!hresetn)
        (mask_reg && latch_reg && !clr_ok) |=> latch_reg;
    endproperty
    a_mask_keeps: assert property (p_mask_keeps) else $error("mask dropped latch");

    property p_req_needs_latch;
        @(posedge hclk) disable iff (!hresetn)
        vec_req |-> latch_reg;
    endproperty
    a_req_needs_latch: assert property (p_req_needs_latch) else $error("request w/o latch");

    property p_level_ack_low;
        @(posedge hclk) disable iff (!hresetn)
        (mode_reg && latch_reg && !irq_pin_n && ack) |=> latch_reg;
    endproperty
    a_level_ack_low: assert property (p_level_ack_low) else $error("dropped while low");

    property p_level_wait_ack;
        @(posedge hclk) disable iff (!hresetn)
        (mode_reg && latch_reg && irq_pin_n && !ack && !acked_reg) |=> latch_reg;
    endproperty
    a_level_wait_ack: assert property (p_level_wait_ack) else $error("dropped w/o ack");

    property p_level_drop;
        @(posedge hclk) disable iff (!hresetn)
        (mode_reg && irq_pin_n && acked_reg) |=> !latch_reg;
    endproperty
    a_level_drop: assert property (p_level_drop) else $error("level request stuck");

    property p_acked_mode0;
        @(posedge hclk) disable iff (!hresetn)
        !mode_reg |=> !acked_reg;
    endproperty
    a_acked_mode0: assert property (p_acked_mode0) else $error("ack memory in edge mode");

    property p_rd_mode;
        @(posedge hclk) disable iff (!hresetn)
        rd_ctrl |=> (hrdata[CTRL_MODE_POS] == $past(mode_reg));
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode read wrong");

    property p_rd_mask;
        @(posedge hclk) disable iff (!hresetn)
        rd_ctrl |=> (hrdata[CTRL_MASK_POS] == $past(mask_reg));
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");

    property p_rd_latch;
        @(posedge hclk) disable iff (!hresetn)
        rd_ctrl |=> (hrdata[CTRL_REQ_POS] == $past(latch_reg));
    endproperty
    a_rd_latch: assert property (p_rd_latch) else $error("latch read wrong");

    property p_rd_pin;
        @(posedge hclk) disable iff (!hresetn)
        rd_ctrl |=> (hrdata[CTRL_PIN_POS] == $past(irq_pin_n));
    endproperty
    a_rd_pin: assert property (p_rd_pin) else $error("pin read wrong");

    property p_stat_edge;
        @(posedge hclk) disable iff (!hresetn)
        fall |=> stat_reg[EV_EDGE_POS];
    endproperty
    a_stat_edge: assert property (p_stat_edge) else $error("edge status missed");

    property p_stat_ack;
        @(posedge hclk) disable iff (!hresetn)
        ack |=> stat_reg[EV_ACK_POS];
    endproperty
    a_stat_ack: assert property (p_stat_ack) else $error("ack status missed");

    property p_unmask;
        @(posedge hclk) disable iff (!hresetn)
        ($fell(mask_reg) && latch_reg && !clr_ok && !interrupt_mask_flag) |=> vec_req;
    endproperty
    a_unmask: assert property (p_unmask) else $error("unmask lost request");

    property p_global_release;
        @(posedge hclk) disable iff (!hresetn)
        ($fell(interrupt_mask_flag) && !mask_reg && latch_reg && !clr_ok) |=> vec_req;
    endproperty
    a_global_release: assert property (p_global_release) else $error("global unmask lost");

    property p_fetch_mode0;
        @(posedge hclk) disable iff (!hresetn)
        (vec_fetch && !mode_reg && !fall) |=> !latch_reg;
    endproperty
    a_fetch_mode0: assert property (p_fetch_mode0) else $error("fetch did not clear");

    property p_swack_mode0;
        @(posedge hclk) disable iff (!hresetn)
        (sw_ack && !mode_reg && !fall) |=> !latch_reg;
    endproperty
    a_swack_mode0: assert property (p_swack_mode0) else $error("write ack did not clear");

    property p_no_spont;
        @(posedge hclk) disable iff (!hresetn)
        (!fall && !level_hold && !latch_reg) |=> !latch_reg;
    endproperty
    a_no_spont: assert property (p_no_spont) else $error("latch set by itself");

    property p_mode_write;
        @(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> (mode_reg == $past(hwdata[CTRL_MODE_POS]));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");
endmodule : eirq_latch

// ===== core/eirq_pkg.sv
// Package for the external interrupt request latch block.
// Assumes a single AHB-Lite slave on a 25 MHz bus clock.
package eirq_pkg;
    // Register byte offsets
    localparam logic [7:0] EIRQ_CTRL_OFS = 8'h00;   // irq_status_control_reg
    localparam logic [7:0] EIRQ_STAT_OFS = 8'h04;   // sticky event status
    localparam logic [7:0] EIRQ_MASK_OFS = 8'h08;   // event mask
    // Control register fields
    localparam int CTRL_MODE_POS  = 0;
    localparam int CTRL_MASK_POS  = 1;
    localparam int CTRL_ACK_POS   = 2;
    localparam int CTRL_REQ_POS   = 3;
    localparam int CTRL_PIN_POS   = 4;
    // Status and mask fields
    localparam int EV_EDGE_POS    = 0;
    localparam int EV_ACK_POS     = 1;
    localparam int EV_W           = 2;
    // Reset values
    localparam logic [EV_W-1:0] EV_RESET = 2'h0;
    localparam logic            MODE_RESET = 1'b0;
    localparam logic            MASK_RESET = 1'b0;
    localparam logic [31:0]     RDATA_RESET = 32'h0000_0000;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage : eirq_pkg

// ===== dv/eirq_pin_model.sv
// Model of the switch that drives the active-low request pin.
// Assumes the bench commands the level; the pin moves only on hclk edges.
`timescale 1ns/100ps
module eirq_pin_model (
    input  wire logic hclk,
    input  wire logic level_cmd,
    output logic      irq_pin_n
);
    // Registered so the pin stays synchronous to hclk, as the design expects
    always_ff @(posedge hclk) begin
        irq_pin_n <= level_cmd;
    end
endmodule : eirq_pin_model

// ===== dv/external_irq_latch_tb_top.sv
// Self-checking bench for the external interrupt request latch.
// Assumes one AHB-Lite master (this bench) and the pin model on the far side.
`timescale 1ns/100ps
module external_irq_latch_tb_top;
    import eirq_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, vec_fetch, interrupt_mask_flag, pin_cmd;
    logic        hreadyout, hresp, irq_pin_n, vec_req, pin_level, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          failures = 0;
    int          checked = 0;
    int          cyc = 0;

    eirq_latch eirq_latch_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_pin_n(irq_pin_n),
        .vec_fetch(vec_fetch), .interrupt_mask_flag(interrupt_mask_flag), .vec_req(vec_req),
        .pin_level(pin_level), .irq(irq));
    eirq_pin_model eirq_pin_model_i (.hclk(hclk), .level_cmd(pin_cmd), .irq_pin_n(irq_pin_n));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    task final_report;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Cuts a hang short; the whole run needs under two hundred cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            final_report;
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Single word transfer; waits on hready in both phases
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task wt(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask : wt

    // Model register plus edge detect plus output register
    task pin(input logic v);
        pin_cmd <= v;
        wt(4);
    endtask : pin

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        vec_fetch = 1'b0;
        interrupt_mask_flag = 1'b0;
        pin_cmd = 1'b1;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        wt(2);
        chk({vec_req, pin_level, irq, hresp}, 32'h4);
        xfer(1'b0, EIRQ_CTRL_OFS, 32'h0);
        chk(rd, 32'h10);
        xfer(1'b0, EIRQ_MASK_OFS, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        $display("test reset done");
        pin(1'b0);
        chk({vec_req, pin_level}, 32'h2);
        pin(1'b1);
        chk(vec_req, 32'h1);
        xfer(1'b1, EIRQ_CTRL_OFS, 32'h2);
        wt(3);
        chk(vec_req, 32'h0);
        xfer(1'b0, EIRQ_CTRL_OFS, 32'h0);
        chk(rd, 32'h1A);
        xfer(1'b1, EIRQ_CTRL_OFS, 32'h0);
        wt(3);
        chk(vec_req, 32'h1);
        interrupt_mask_flag <= 1'b1;
        wt(3);
        chk(vec_req, 32'h0);
        interrupt_mask_flag <= 1'b0;
        @(posedge hclk) vec_fetch <= 1'b1;
        @(posedge hclk) vec_fetch <= 1'b0;
        wt(3);
        chk(vec_req, 32'h0);
        xfer(1'b0, EIRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h3);
        xfer(1'b1, EIRQ_MASK_OFS, 32'h1);
        wt(2);
        chk(irq, 32'h1);
        xfer(1'b1, EIRQ_STAT_OFS, 32'h1);
        wt(2);
        chk(irq, 32'h0);
        $display("test edge mode done");
        pin(1'b0);
        xfer(1'b1, EIRQ_CTRL_OFS, 32'h4);
        wt(3);
        chk(vec_req, 32'h0);
        xfer(1'b0, EIRQ_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        pin(1'b1);
        pin(1'b0);
        chk(vec_req, 32'h1);
        pin(1'b1);
        $display("test soft ack done");
        xfer(1'b1, EIRQ_CTRL_OFS, 32'h5);
        wt(3);
        chk(vec_req, 32'h0);
        pin(1'b0);
        xfer(1'b1, EIRQ_CTRL_OFS, 32'h5);
        wt(3);
        chk(vec_req, 32'h1);
        pin(1'b1);
        chk(vec_req, 32'h0);
        pin(1'b0);
        pin(1'b1);
        chk(vec_req, 32'h1);
        xfer(1'b1, EIRQ_CTRL_OFS, 32'h5);
        wt(3);
        chk(vec_req, 32'h0);
        $display("test level mode done");
        pin(1'b0);
        @(posedge hclk) hresetn <= 1'b0;
        wt(2);
        chk(vec_req, 32'h0);
        hresetn <= 1'b1;
        wt(2);
        chk(vec_req, 32'h0);
        xfer(1'b0, EIRQ_CTRL_OFS, 32'h0);
        chk(rd[0], 32'h0);
        $display("test mid-run reset done");
        final_report;
    end
endmodule : external_irq_latch_tb_top
